// *** rtl/eebc_top.sv ***
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
// ----------------------------------------
// Emergency evacuation and brake control
// ----------------------------------------
module eebc_top
    import eebc_pkg::*;
#(
    parameter int HALF_PERIOD_CYC = EEBC_HALF_PERIOD_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Lift control inputs
    input wire logic drive_enable,
    input wire logic downward_direction_input,
    input wire logic [1:0] speed_select,
    input wire logic power_fail_set_switch_input,
    input wire logic monitor_input,
    // Drive measurements
    input wire logic car_heavier_meas,
    input wire logic [15:0] car_speed,
    input wire logic brake_open_fb,
    // Outputs to lift control and power stage
    output logic evac_direction_output_reg,
    output logic pulsed_brake_output_reg,
    output logic motor_short_reg,
    output logic monitor_active_reg,
    output logic drive_running_reg
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] set1_reg;
    logic [31:0] set2_reg;
    logic [7:0] cmd_reg;
    logic [7:0] aw_addr_reg;
    logic aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_held_reg;
    logic [31:0] dist_reg;
    logic [31:0] rdata_next;
    logic rmapped;
    logic wmapped;
    logic do_write;
    logic travel_req;
    logic journey_start;
    logic car_heavier;
    logic [31:0] active_set;
    logic [15:0] first_speed_limit;
    logic contact_closed;
    logic evac_down_req;
    logic por_done_reg;
    eebc_stut_t stut_mode;
    logic [7:0] fb_object;

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    // Address and data taken in any order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

    // Capture write address and data
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (do_write)
                w_held_reg <= 1'b0;
        end
    end

    // Decode of writable offsets
    always_comb
    begin
        case (aw_addr_reg & 8'hFC)
            EEBC_CTRL_ADDR, EEBC_SET1_ADDR, EEBC_SET2_ADDR, EEBC_CMD_ADDR: wmapped = 1'b1;
            default: wmapped = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= EEBC_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wmapped ? EEBC_RESP_OKAY : EEBC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Byte-lane merge helper
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            if (strb[i])
                old[i*8 +: 8] = nw[i*8 +: 8];
        return old;
    endfunction

    // ----------------------------------------
    // Registers written by software
    // ----------------------------------------
    // Control register, copy bit self-clearing
    always_ff @(posedge clock)
    begin
        if (reset)
            ctrl_reg <= EEBC_CTRL_RESET;
        else if (do_write && (aw_addr_reg & 8'hFC) == EEBC_CTRL_ADDR && !monitor_active_reg)
            ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg);
        else
            ctrl_reg[EEBC_CTRL_COPY_BIT] <= 1'b0; // R8
    end

    // Parameter set one, speed limit configurable
    always_ff @(posedge clock)
    begin
        if (reset)
            set1_reg <= EEBC_SET_RESET;
        else if (do_write && (aw_addr_reg & 8'hFC) == EEBC_SET1_ADDR && !monitor_active_reg)
            set1_reg <= merge(set1_reg, w_data_reg, w_strb_reg); // R17
    end

    // Parameter set two, loaded by copy command
    always_ff @(posedge clock)
    begin
        if (reset)
            set2_reg <= EEBC_SET_RESET;
        else if (ctrl_reg[EEBC_CTRL_COPY_BIT])
            set2_reg <= set1_reg; // R8
        else if (do_write && (aw_addr_reg & 8'hFC) == EEBC_SET2_ADDR && !monitor_active_reg)
            set2_reg <= merge(set2_reg, w_data_reg, w_strb_reg);
    end

    // Serial command byte one from lift control
    always_ff @(posedge clock)
    begin
        if (reset)
            cmd_reg <= 8'h00;
        else if (do_write && (aw_addr_reg & 8'hFC) == EEBC_CMD_ADDR && w_strb_reg[0])
            cmd_reg <= w_data_reg[7:0];
    end

    // ----------------------------------------
    // Parameter set selection and monitor
    // ----------------------------------------
    // Power fail selects the second set
    assign active_set = power_fail_set_switch_input ? set2_reg : set1_reg; // R6
    assign first_speed_limit = active_set[EEBC_SET_LIMIT_MSB:0];

    // Monitor input sampled once after reset
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            por_done_reg <= 1'b0;
            monitor_active_reg <= 1'b0;
        end
        else if (!por_done_reg)
        begin
            por_done_reg <= 1'b1;
            monitor_active_reg <= monitor_input; // R9
        end
    end

    // ----------------------------------------
    // Journey start and load evaluation
    // ----------------------------------------
    // Travel request needs enable and a speed, with monitor off
    assign evac_down_req = downward_direction_input || cmd_reg[EEBC_CMD_DOWN_BIT]; // R5
    assign travel_req = drive_enable && (speed_select != 2'b00) && !monitor_active_reg; // R7 R10

    // Running flag to lift control; its rise marks a journey start
    always_ff @(posedge clock)
    begin
        if (reset)
            drive_running_reg <= 1'b0;
        else
            drive_running_reg <= travel_req;
    end
    assign journey_start = travel_req && !drive_running_reg;

    eebc_load_eval u_load_eval
    (
        .clock(clock),
        .reset(reset),
        .journey_start(journey_start),
        .car_heavier_meas(car_heavier_meas),
        .inhibit(monitor_active_reg),
        .car_heavier_reg(car_heavier)
    );

    // Direction output closed when car heavier
    always_ff @(posedge clock)
    begin
        if (reset)
            evac_direction_output_reg <= 1'b0;
        else
            evac_direction_output_reg <= car_heavier; // R2
    end

    // Fieldbus direction object value
    assign fb_object = car_heavier ? EEBC_OBJ_DOWN : EEBC_OBJ_UP; // R4

    // ----------------------------------------
    // Stutter brake
    // ----------------------------------------
    // Mode choice from rescue, encoder and stop state
    always_comb
    begin
        if (!ctrl_reg[EEBC_CTRL_STUTTER_EN_BIT])
            stut_mode = EEBC_STUT_OFF; // R19
        else if (ctrl_reg[EEBC_CTRL_STOPPED_BIT] || !ctrl_reg[EEBC_CTRL_ENC_OK_BIT])
            stut_mode = EEBC_STUT_TIME; // R15
        else if (ctrl_reg[EEBC_CTRL_RESCUE_BIT])
            stut_mode = EEBC_STUT_SPEED; // R13
        else
            stut_mode = EEBC_STUT_OFF;
    end

    eebc_stutter #(.HALF_PERIOD_CYC(HALF_PERIOD_CYC)) u_stutter
    (
        .clock(clock),
        .reset(reset),
        .mode(stut_mode),
        .speed(car_speed),
        .speed_limit(first_speed_limit),
        .brake_mon_en(ctrl_reg[EEBC_CTRL_BRK_MON_BIT]),
        .brake_open_fb(brake_open_fb),
        .contact_closed_reg(contact_closed)
    );

    // Brake and winding short outputs
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pulsed_brake_output_reg <= 1'b0;
            motor_short_reg <= 1'b0;
        end
        else
        begin
            pulsed_brake_output_reg <= contact_closed;
            motor_short_reg <= ctrl_reg[EEBC_CTRL_NO_CONTACTOR_BIT] && stut_mode != EEBC_STUT_OFF; // R18
        end
    end

    // ----------------------------------------
    // Monitor distance
    // ----------------------------------------
    // Signed distance while monitor active
    always_ff @(posedge clock)
    begin
        if (reset)
            dist_reg <= 32'h0000_0000;
        else if (monitor_active_reg)
            dist_reg <= evac_down_req ? dist_reg - {16'h0000, car_speed}
                                      : dist_reg + {16'h0000, car_speed}; // R10
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // Read mux
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        rmapped = 1'b1;
        case (s_axi_araddr & 8'hFC)
            EEBC_CTRL_ADDR: rdata_next = ctrl_reg;
            EEBC_SET1_ADDR: rdata_next = set1_reg;
            EEBC_SET2_ADDR: rdata_next = set2_reg;
            EEBC_STAT_ADDR:
            begin
                rdata_next[EEBC_STAT_HEAVY_BIT] = car_heavier; // R3
                rdata_next[EEBC_STAT_POWER_FAIL_SET_SWITCH_INPUT_BIT] = power_fail_set_switch_input;
                rdata_next[EEBC_STAT_MON_BIT] = monitor_active_reg;
                rdata_next[EEBC_STAT_ARROW2_BIT] = car_speed > first_speed_limit; // R11
                rdata_next[EEBC_STAT_BRAKE_BIT] = pulsed_brake_output_reg;
                rdata_next[EEBC_STAT_SHORT_BIT] = motor_short_reg;
                rdata_next[EEBC_STAT_MODE_LSB +: 2] = stut_mode;
                rdata_next[EEBC_STAT_OBJ_LSB +: 8] = fb_object;
                rdata_next[16 + EEBC_SERIAL_DIR_BIT] = car_heavier; // R3
            end
            EEBC_SPEED_ADDR: rdata_next = {15'h0000, evac_down_req, car_speed};
            EEBC_DIST_ADDR: rdata_next = dist_reg;
            EEBC_CMD_ADDR: rdata_next = {24'h000000, cmd_reg};
            default: rmapped = 1'b0;
        endcase
    end

    // Read data and response
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= EEBC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rmapped ? EEBC_RESP_OKAY : EEBC_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule // eebc_top

// *** rtl/eebc_pkg.sv ***
// Operation
// R1: At every journey start, measure car versus counterweight balance and keep it.
// R2: Direction output open for lighter car (up), closed for heavier (down).
// R3: Serial status byte 2 bit 2: 0 lighter/up, 1 heavier/down.
// R4: Fieldbus direction object: 1 means up/lighter, 2 means down/heavier.
// R5: Controller requests down by direction input, serial bit 4, or object. The code decodes only the direction input and serial bit 4.
// R6: Power-fail input asserted switches active configuration to second set.
// R7: Controller starts evacuation with enable, direction and speed selection.
// R8: Copy command copies set one into set two, then returns off.
// R9: Monitor activates only if its input is high at power-on.
// R10: Active monitor shows speed, direction, distance and inhibits other functions.
// R11: Monitor shows single arrow below first speed limit, double above it.
// R12: Speed stutter opens brake contact above limit, closes below, repeating.
// R13: Speed stutter chosen during rescue with a working encoder.
// R14: Time stutter toggles brake contact at a fixed 0.5 Hz rate.
// R15: Time stutter chosen when installation stopped or encoder faulty.
// R16: Time stutter runs only if release monitor off or brake reported open.
// R17: Stutter threshold is a configurable speed; 0.06 m/s recommended.
// R18: Without contactors, device shorts motor windings during brake-release evacuation.
// R19: After reset or when stutter inactive, brake contact rests open.
package eebc_pkg;

    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] EEBC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] EEBC_SET1_ADDR = 8'h04;
    localparam logic [7:0] EEBC_SET2_ADDR = 8'h08;
    localparam logic [7:0] EEBC_STAT_ADDR = 8'h0C;
    localparam logic [7:0] EEBC_SPEED_ADDR = 8'h10;
    localparam logic [7:0] EEBC_DIST_ADDR = 8'h14;
    localparam logic [7:0] EEBC_CMD_ADDR = 8'h18;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int EEBC_CTRL_COPY_BIT = 0;
    localparam int EEBC_CTRL_STUTTER_EN_BIT = 1;
    localparam int EEBC_CTRL_BRK_MON_BIT = 2;
    localparam int EEBC_CTRL_NO_CONTACTOR_BIT = 3;
    localparam int EEBC_CTRL_RESCUE_BIT = 4;
    localparam int EEBC_CTRL_ENC_OK_BIT = 5;
    localparam int EEBC_CTRL_STOPPED_BIT = 6;
    localparam logic [31:0] EEBC_CTRL_RESET = 32'h0000_0020;

    // ----------------------------------------
    // Parameter set fields: [15:0] speed limit mm/s, [16] evacuation type
    // ----------------------------------------
    localparam int EEBC_SET_LIMIT_MSB = 15;
    localparam int EEBC_SET_EVA_TYPE_BIT = 16;
    // 0.06 m/s recommended, expressed in mm/s
    localparam logic [31:0] EEBC_SET_RESET = 32'h0000_003C;

    // ----------------------------------------
    // Status and serial bit positions
    // ----------------------------------------
    localparam int EEBC_STAT_HEAVY_BIT = 0;
    localparam int EEBC_STAT_POWER_FAIL_SET_SWITCH_INPUT_BIT = 1;
    localparam int EEBC_STAT_MON_BIT = 2;
    localparam int EEBC_STAT_ARROW2_BIT = 3;
    localparam int EEBC_STAT_BRAKE_BIT = 4;
    localparam int EEBC_STAT_SHORT_BIT = 5;
    localparam int EEBC_STAT_MODE_LSB = 6;
    localparam int EEBC_STAT_OBJ_LSB = 8;
    localparam int EEBC_SERIAL_DIR_BIT = 2;
    localparam int EEBC_CMD_DOWN_BIT = 4;

    // ----------------------------------------
    // Fieldbus direction object values
    // ----------------------------------------
    localparam logic [7:0] EEBC_OBJ_UP = 8'h01;
    localparam logic [7:0] EEBC_OBJ_DOWN = 8'h02;

    // ----------------------------------------
    // Timing: 0.5 Hz stutter, toggle each half period
    // ----------------------------------------
    localparam int EEBC_CLK_HZ = 50000000;
    localparam int EEBC_HALF_PERIOD_CYC = EEBC_CLK_HZ;

    // ----------------------------------------
    // Stutter modes
    // ----------------------------------------
    typedef enum logic [1:0] {EEBC_STUT_OFF, EEBC_STUT_SPEED, EEBC_STUT_TIME} eebc_stut_t;

    // AXI responses
    localparam logic [1:0] EEBC_RESP_OKAY = 2'h0;
    localparam logic [1:0] EEBC_RESP_SLVERR = 2'h2;

endpackage

// *** rtl/eebc_load_eval.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Load balance capture at journey start
// ----------------------------------------
module eebc_load_eval
    import eebc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Journey start and measurement
    input wire logic journey_start,
    input wire logic car_heavier_meas,
    input wire logic inhibit,
    // Result
    output logic car_heavier_reg
);

    // Keep the balance seen at the latest start
    always_ff @(posedge clock)
    begin
        if (reset)
            car_heavier_reg <= 1'b0;
        else if (journey_start && !inhibit)
            car_heavier_reg <= car_heavier_meas; // R1
    end

endmodule // eebc_load_eval

// *** rtl/eebc_stutter.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Stutter brake pulse generator
// ----------------------------------------
module eebc_stutter
    import eebc_pkg::*;
#(
    parameter int HALF_PERIOD_CYC = EEBC_HALF_PERIOD_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Mode and inputs
    input wire eebc_stut_t mode,
    input wire logic [15:0] speed,
    input wire logic [15:0] speed_limit,
    input wire logic brake_mon_en,
    input wire logic brake_open_fb,
    // Contact closed means brake released
    output logic contact_closed_reg
);

    logic [31:0] cycle_count_reg;
    logic time_ok;

    // Time cycle needs monitor off or brake reported open
    assign time_ok = !brake_mon_en || brake_open_fb; // R16

    // Half period counter
    always_ff @(posedge clock)
    begin
        if (reset || mode != EEBC_STUT_TIME || !time_ok || cycle_count_reg == 32'(HALF_PERIOD_CYC - 1))
            cycle_count_reg <= 32'h0000_0000;
        else
            cycle_count_reg <= cycle_count_reg + 32'h0000_0001;
    end

    // Contact drive per mode
    always_ff @(posedge clock)
    begin
        if (reset)
            contact_closed_reg <= 1'b0; // R19
        else
        begin
            case (mode)
                EEBC_STUT_SPEED:
                begin
                    if (speed > speed_limit)
                        contact_closed_reg <= 1'b0; // R12
                    else if (speed < speed_limit)
                        contact_closed_reg <= 1'b1; // R12
                end
                EEBC_STUT_TIME:
                begin
                    if (!time_ok)
                        contact_closed_reg <= 1'b0; // R16
                    else if (cycle_count_reg == 32'(HALF_PERIOD_CYC - 1))
                        contact_closed_reg <= !contact_closed_reg; // R14
                end
                default: contact_closed_reg <= 1'b0; // R19
            endcase
        end
    end

endmodule // eebc_stutter

// *** testbench/eebc_props.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module eebc_props
    import eebc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Lift side
    input wire logic drive_enable,
    input wire logic [1:0] speed_select,
    input wire logic car_heavier_meas,
    input wire logic evac_direction_output_reg,
    input wire logic pulsed_brake_output_reg,
    input wire logic motor_short_reg,
    input wire logic monitor_active_reg,
    input wire logic drive_running_reg
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    // Journey start edge and age since reset
    logic js_d;
    logic [3:0] age;
    wire js = drive_enable && (speed_select != 2'h0);
    always_ff @(posedge clock)
    begin
        js_d <= !reset && js;
    end
    always_ff @(posedge clock)
    begin
        if (reset)
            age <= 4'h0;
        else if (age != 4'hF)
            age <= age + 4'h1;
    end
    property p_rst; $fell(reset) |-> !pulsed_brake_output_reg && !motor_short_reg; endproperty
    property p_dir; js && !js_d && !monitor_active_reg |-> ##2 evac_direction_output_reg == $past(car_heavier_meas, 2);
    endproperty
    property p_hold; $changed(evac_direction_output_reg) |-> $past(js && !js_d, 2); endproperty
    property p_mon; $rose(monitor_active_reg) |-> age < 4'h4; endproperty
    property p_inh; monitor_active_reg |-> !drive_running_reg && !pulsed_brake_output_reg; endproperty
    property p_run; js && !monitor_active_reg |-> ##[1:2] drive_running_reg; endproperty
    property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rst: assert property (p_rst) else $error("outputs busy after reset");
    a_dir: assert property (p_dir) else $error("direction not captured");
    a_hold: assert property (p_hold) else $error("direction changed mid journey");
    a_mon: assert property (p_mon) else $error("monitor started late");
    a_inh: assert property (p_inh) else $error("function ran under monitor");
    a_run: assert property (p_run) else $error("travel request missed");
    a_wr: assert property (p_wr) else $error("write response late");
    a_rd: assert property (p_rd) else $error("read data late");
    c_js: cover property (js && !js_d);
    c_mon: cover property ($rose(monitor_active_reg));
    c_brk: cover property ($changed(pulsed_brake_output_reg));
endmodule // eebc_props

bind eebc_top eebc_props u_eebc_props (.*);

// *** testbench/eebc_lift_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Lift control model
// ----------------------------------------
module eebc_lift_model
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Bench commands
    input wire logic go,
    input wire logic down,
    input wire logic pf,
    // Travel and power-fail signals
    output logic drive_enable,
    output logic downward_direction_input,
    output logic [1:0] speed_select,
    output logic power_fail_set_switch_input
);
    // Enable, direction and speed raised together
    always_ff @(posedge clock)
    begin
        drive_enable <= !reset && go;
        downward_direction_input <= !reset && go && down;
        speed_select <= (!reset && go) ? 2'h1 : 2'h0;
    end
    // Mains failure flag
    always_ff @(posedge clock)
    begin
        power_fail_set_switch_input <= !reset && pf;
    end
endmodule // eebc_lift_model

// *** testbench/tb.sv ***
`timescale 1ns/100ps
module tb;
    import eebc_pkg::*;
    localparam int HP = 8;
    logic clock = 0, reset = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, speed_select;
    logic drive_enable, downward_direction_input, power_fail_set_switch_input;
    logic monitor_input = 0, car_heavier_meas = 0, brake_open_fb = 0, go = 0, down = 0, pf = 0;
    logic [15:0] car_speed = 0;
    logic evac_direction_output_reg, pulsed_brake_output_reg, motor_short_reg, monitor_active_reg, drive_running_reg;
    int n_errors = 0, n_checks = 0, n;
    eebc_top #(.HALF_PERIOD_CYC(HP)) u_eebc_top (.*);
    eebc_lift_model u_eebc_lift_model (.*);
    // Clock
    initial forever #10 clock = ~clock;
    // Compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bus write
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = EEBC_RESP_OKAY);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            n++;
        end
        while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'b0;
        chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
    endtask
    // Bus read into rv
    task automatic rd(input logic [7:0] a, input logic [1:0] er = EEBC_RESP_OKAY);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            n++;
        end
        while (!s_axi_rvalid && n < 40);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        chk({s_axi_rvalid, s_axi_rresp}, {1'b1, er});
    endtask
    // Wait for brake output level
    task automatic wbrk(input logic v);
        n = 0;
        while (pulsed_brake_output_reg !== v && n < 40)
        begin
            @(posedge clock);
            n++;
        end
        chk(pulsed_brake_output_reg, v);
    endtask
    // Verdict
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #400000;
        n_errors++;
        wrap_up;
    end
    // Tests
    initial
    begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rd(EEBC_CTRL_ADDR);
        chk(rv, EEBC_CTRL_RESET);
        rd(EEBC_SET1_ADDR);
        chk(rv, EEBC_SET_RESET);
        rd(8'h1C, EEBC_RESP_SLVERR);
        wr(8'h1C, 32'h0000_0001, EEBC_RESP_SLVERR);
        for (int i = 0; i < 2; i++)
        begin
            car_heavier_meas <= !i[0];
            down <= !i[0];
            go <= 1'b1;
            repeat (6) @(posedge clock);
            chk(evac_direction_output_reg, !i[0]);
            go <= 1'b0;
            rd(EEBC_STAT_ADDR);
            chk(rv[0], !i[0]);
            chk(rv[15:8], i[0] ? EEBC_OBJ_UP : EEBC_OBJ_DOWN);
            chk(rv[18], !i[0]);
        end
        wr(EEBC_CMD_ADDR, 32'h0000_0010);
        rd(EEBC_SPEED_ADDR);
        chk(rv[16], 1'b1);
        pf <= 1'b1;
        repeat (3) @(posedge clock);
        rd(EEBC_STAT_ADDR);
        chk(rv[1], 1'b1);
        wr(EEBC_SET1_ADDR, 32'h0000_0064);
        wr(EEBC_CTRL_ADDR, 32'h0000_0021);
        rd(EEBC_SET2_ADDR);
        chk(rv, 32'h0000_0064);
        rd(EEBC_CTRL_ADDR);
        chk(rv[0], 1'b0);
        wr(EEBC_CTRL_ADDR, 32'h0000_0032);
        car_speed <= 16'h00C8;
        wbrk(1'b0);
        car_speed <= 16'h0032;
        wbrk(1'b1);
        rd(EEBC_STAT_ADDR);
        chk(rv[7:6], 2'h1);
        chk(rv[3], 1'b0);
        car_speed <= 16'h00C8;
        wbrk(1'b0);
        wr(EEBC_CTRL_ADDR, 32'h0000_0042);
        wbrk(1'b1);
        wbrk(1'b0);
        wbrk(1'b1);
        wbrk(1'b0);
        chk(n, HP);
        rd(EEBC_STAT_ADDR);
        chk(rv[7:6], 2'h2);
        wr(EEBC_CTRL_ADDR, 32'h0000_0046);
        wbrk(1'b0);
        repeat (2 * HP) @(posedge clock);
        chk(pulsed_brake_output_reg, 1'b0);
        brake_open_fb <= 1'b1;
        wbrk(1'b1);
        wr(EEBC_CTRL_ADDR, 32'h0000_0020);
        wbrk(1'b0);
        monitor_input <= 1'b1;
        repeat (4) @(posedge clock);
        chk(monitor_active_reg, 1'b0);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
        chk(monitor_active_reg, 1'b1);
        go <= 1'b1;
        repeat (6) @(posedge clock);
        chk(drive_running_reg, 1'b0);
        wr(EEBC_CTRL_ADDR, 32'h0000_0002);
        rd(EEBC_CTRL_ADDR);
        chk(rv, EEBC_CTRL_RESET);
        wrap_up;
    end
endmodule // tb
